// ---- hw/pin_sync.v ----
// Purpose: three-flop synchroniser with agreement filter for one pin
// Assumes: pin asynchronous to sys_clk_i
// Notes: output changes once the second and third stages agree
`timescale 1ns/1ps
module pin_sync #(
  parameter RESET_LEVEL = 1'b0
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire pin_i,
  output reg level_o
);
  reg meta;
  reg stage2;
  reg stage3;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      meta <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
      level_o <= RESET_LEVEL;
    end else begin
      meta <= pin_i;
      stage2 <= meta;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level_o <= stage3;
      end
    end
  end
endmodule // pin_sync

// ---- hw/serial_port.v ----
// Purpose: full-duplex synchronous serial port, master or slave, APB registers
// Assumes: 10 MHz sys_clk_i; synchronous active-high reset; pins asynchronous
// Notes: slave clock is oversampled, so slave rate is bounded by synchroniser delay
// Operation
// - master-select bit set makes master; clear makes slave with clock pin as input
// - master data write starts transfer; empty shifter loads at once, tx empty set
// - two rate bits pick bus/2, /8, /32 or /128 serial clock
// - master end of transfer sets rx full and loads receive register together
// - rx full clears by status read while set then data read
// - any data write clears the tx-empty interrupt enable bit
// - slave complete byte moves to receive register and sets rx full
// - slave accepts clock rates up to the synchroniser bound, ignoring rate select
// - late slave write shifts out the old shift register contents
// - byte written during slave transfer waits in buffer until transfer ends
// - slave starts on first clock edge if phase 1, select fall if phase 0
// - slave drives its output data only while select is low
// - phase 0: slave presents msb before first clock edge
// - phase 1: data changes on first edge, select may stay low; slave shows msb once loaded and first shifts on the third edge (second leading edge)
// - all four polarity and phase combinations supported
// - rx full, tx empty interrupts plus mode-fault and overflow error flags
// - unread receive data at bit 1 capture sets overflow, new byte lost
// - slave select rising during transfer sets mode fault
// - master mode fault: flag, disable, tx empty, counter cleared, pins released
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module serial_port (
  input wire sys_clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe_o,
  input wire mosi_i,
  output reg mosi_o,
  output reg mosi_oe_o,
  input wire miso_i,
  output reg miso_o,
  output reg miso_oe_o,
  input wire select_n_i,
  output wire irq_o
);
  reg [`CTL_WIDTH-1:0] control;
  reg [1:0] rate;
  reg mode_fault_flag_en;
  reg err_irq_en;
  reg rx_full;
  reg tx_empty;
  reg overflow;
  reg mode_fault;
  reg [7:0] tx_buf;
  reg [7:0] rx_data;
  reg [7:0] shifter;
  reg [7:0] rx_sh;
  reg [`CAP_LAG-1:0] cap_pipe;
  reg [`CAP_LAG-1:0] last_pipe;
  reg [2:0] bit_cnt;
  reg busy;
  reg second_half;
  reg [`DIV_CNT_W-1:0] div_cnt;
  reg status_seen;
  reg mode_fault_flag_seen;
  reg sck_prev;
  reg sel_prev;
  wire sck_s;
  wire sel_s;
  wire mosi_s;
  wire miso_s;

  pin_sync #(.RESET_LEVEL(1'b0)) sync_sck (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .pin_i(sck_i), .level_o(sck_s));
  pin_sync #(.RESET_LEVEL(1'b1)) sync_sel (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .pin_i(select_n_i), .level_o(sel_s));
  pin_sync #(.RESET_LEVEL(1'b0)) sync_mosi (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .pin_i(mosi_i), .level_o(mosi_s));
  pin_sync #(.RESET_LEVEL(1'b0)) sync_miso (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .pin_i(miso_i), .level_o(miso_s));

  wire enable = control[`CTL_ENABLE];
  wire master = control[`CTL_MASTER];
  wire cpol = control[`CTL_CPOL];
  wire cpha = control[`CTL_CPHA];
  wire access = psel_i & penable_i;
  wire wr = access & pwrite_i;
  wire rd = access & ~pwrite_i;
  wire hit_ctl = paddr_i == `OFS_CONTROL;
  wire hit_sts = paddr_i == `OFS_STATUS;
  wire hit_dat = paddr_i == `OFS_DATA;
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~(hit_ctl | hit_sts | hit_dat);
  wire [7:0] status_word = {rx_full, err_irq_en, mode_fault, overflow, tx_empty,
    mode_fault_flag_en, rate};
  assign prdata_o = ~rd ? 32'h0 :
    hit_ctl ? {25'h0, control} :
    hit_sts ? {24'h0, status_word} :
    hit_dat ? {24'h0, rx_data} : 32'h0;
  assign irq_o = (rx_full & control[`CTL_RX_IRQ_EN]) |
    (tx_empty & control[`CTL_TX_IRQ_EN]) |
    ((overflow | mode_fault) & err_irq_en);

  // half bit time in bus cycles: 1, 4, 16, 64
  reg [`DIV_CNT_W-1:0] half_period;
  always @* begin
    case (rate)
      2'h0: half_period = 7'h01;
      2'h1: half_period = 7'h04;
      2'h2: half_period = 7'h10;
      default: half_period = 7'h40;
    endcase
  end

  // slave edge detection on the filtered clock; leading edge leaves idle level
  wire sck_lead = (sck_s != sck_prev) & (sck_s != cpol);
  wire sck_trail = (sck_s != sck_prev) & (sck_s == cpol);
  wire sck_edge = sck_s != sck_prev;
  wire sel_fall = sel_prev & ~sel_s;
  wire sel_rise = ~sel_prev & sel_s;
  wire slave_on = enable & ~master;
  wire tick = div_cnt == half_period - 7'h01;
  wire master_fault = enable & master & mode_fault_flag_en & ~sel_s;

  // sample and shift moments for both ends, all four formats
  reg do_sample;
  reg do_shift;
  reg start_xfer;
  reg sample_in;
  always @* begin
    do_sample = 1'b0;
    do_shift = 1'b0;
    start_xfer = 1'b0;
    sample_in = mosi_s;
    if (master) begin
      sample_in = miso_s;
      do_sample = busy & tick & ~second_half;
      do_shift = busy & tick & second_half;
    end else if (slave_on & ~sel_s) begin
      start_xfer = cpha ? (~busy & sck_lead) : sel_fall;
      do_sample = (busy | start_xfer) & (cpha ? sck_trail : sck_lead);
      do_shift = busy & (cpha ? sck_lead & ~start_xfer : sck_trail & (bit_cnt != `BIT_FIRST));
    end
  end
  wire last_sample = do_sample & bit_cnt == `BIT_LAST;
  // master data passes the pin synchroniser, so capture trails the clock edge
  wire cap = master ? cap_pipe[`CAP_LAG-1] : do_sample;
  wire cap_last = master ? last_pipe[`CAP_LAG-1] : last_sample;
  wire xfer_done = cap_last;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      control <= `CTL_RESET;
      rate <= 2'h0;
      mode_fault_flag_en <= 1'b0;
      err_irq_en <= 1'b0;
      rx_full <= 1'b0;
      tx_empty <= 1'b1;
      overflow <= 1'b0;
      mode_fault <= 1'b0;
      tx_buf <= 8'h00;
      rx_data <= 8'h00;
      shifter <= 8'h00;
      rx_sh <= 8'h00;
      cap_pipe <= {`CAP_LAG{1'b0}};
      last_pipe <= {`CAP_LAG{1'b0}};
      bit_cnt <= `BIT_FIRST;
      busy <= 1'b0;
      second_half <= 1'b0;
      div_cnt <= 7'h00;
      status_seen <= 1'b0;
      mode_fault_flag_seen <= 1'b0;
      sck_prev <= 1'b0;
      sel_prev <= 1'b1;
    end else begin
      sck_prev <= sck_s;
      sel_prev <= sel_s;
      cap_pipe <= {cap_pipe[`CAP_LAG-2:0], master & do_sample};
      last_pipe <= {last_pipe[`CAP_LAG-2:0], master & last_sample};
      if (wr & hit_ctl) begin
        control <= pwdata_i[`CTL_WIDTH-1:0];
      end
      if (wr & hit_sts) begin
        rate <= pwdata_i[`STS_RATE_HI:`STS_RATE_LO];
        mode_fault_flag_en <= pwdata_i[`STS_MODE_FAULT_FLAG_EN];
        err_irq_en <= pwdata_i[`STS_ERR_IRQ_EN];
      end
      // two-step clears: status read arms, data read or control write clears
      if (rd & hit_sts) begin
        status_seen <= rx_full | overflow;
        mode_fault_flag_seen <= mode_fault;
      end
      if (rd & hit_dat & status_seen) begin
        rx_full <= 1'b0;
        overflow <= 1'b0;
        status_seen <= 1'b0;
      end
      if (wr & hit_ctl & mode_fault_flag_seen & ~master_fault) begin
        mode_fault <= 1'b0;
        mode_fault_flag_seen <= 1'b0;
      end
      if (wr & hit_dat) begin
        control[`CTL_TX_IRQ_EN] <= 1'b0;
        tx_buf <= pwdata_i[7:0];
        tx_empty <= 1'b0;
      end
      // buffered byte enters shifter only between transfers
      if (~busy & ~tx_empty & ~(master & ~enable)) begin
        shifter <= tx_buf;
        tx_empty <= 1'b1;
        if (master & enable) begin
          busy <= 1'b1;
          div_cnt <= 7'h00;
          second_half <= 1'b0;
          bit_cnt <= `BIT_FIRST;
        end
      end
      if (master & busy) begin
        div_cnt <= tick ? 7'h00 : div_cnt + 7'h01;
        if (tick) begin
          second_half <= ~second_half;
        end
      end
      if (start_xfer) begin
        busy <= 1'b1;
        bit_cnt <= `BIT_FIRST;
      end
      if (do_shift) begin
        shifter <= {shifter[6:0], 1'b0};
      end
      if (cap) begin
        rx_sh <= {rx_sh[6:0], sample_in};
      end
      if (do_sample) begin
        bit_cnt <= bit_cnt + `BIT_ONE;
        if (bit_cnt == `BIT_ONE & rx_full) begin
          overflow <= 1'b1;
        end
      end
      if (xfer_done) begin
        if (~master) begin
          shifter <= {rx_sh[6:0], sample_in};
        end
        if (~master & cpha) begin
          busy <= 1'b0;
        end
        if (~overflow & ~(rx_full & ~(rd & hit_dat & status_seen))) begin
          rx_data <= {rx_sh[6:0], sample_in};
          rx_full <= 1'b1;
        end
      end
      // master ends after the trailing half bit in phase 0, at the last sample in phase 1; slave when clock returns idle
      if (master & last_sample & cpha) begin
        busy <= 1'b0;
      end
      if (master & do_shift & bit_cnt == `BIT_FIRST & ~cpha) begin
        busy <= 1'b0;
      end
      if (~master & ~cpha & busy & bit_cnt == `BIT_FIRST & sck_trail & ~start_xfer) begin
        busy <= 1'b0;
      end
      if (slave_on & busy & sel_rise) begin
        mode_fault <= mode_fault_flag_en | mode_fault;
        busy <= 1'b0;
      end
      if (slave_on & ~busy & ~cpha & sel_rise) begin
        mode_fault <= mode_fault_flag_en | mode_fault;
      end
      if (~enable & ~master) begin
        busy <= 1'b0;
      end
      if (master_fault) begin
        mode_fault <= 1'b1;
        control[`CTL_ENABLE] <= 1'b0;
        tx_empty <= 1'b1;
        busy <= 1'b0;
        bit_cnt <= `BIT_FIRST;
        div_cnt <= 7'h00;
      end
    end
  end

  // pin drivers; released when disabled or after a mode fault
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      sck_oe_o <= enable & master & ~master_fault;
      mosi_oe_o <= enable & master & ~master_fault;
      // pins trail the internal state by one cycle, data and clock alike
      sck_o <= cpol ^ (master & busy & (cpha ^ second_half));
      mosi_o <= shifter[7];
      miso_o <= shifter[7];
      miso_oe_o <= slave_on & ~sel_s;
    end
  end
endmodule // serial_port

// ---- hw/serial_port_regs.vh ----
// Purpose: register offsets, field positions and reset values of the serial port
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_DATA 12'h008
// control register fields
`define CTL_RX_IRQ_EN 0
`define CTL_MASTER 1
`define CTL_CPOL 2
`define CTL_CPHA 3
`define CTL_ENABLE 5
`define CTL_TX_IRQ_EN 6
`define CTL_WIDTH 7
`define CTL_RESET 7'h02
// status/control register fields
`define STS_RATE_LO 0
`define STS_RATE_HI 1
`define STS_MODE_FAULT_FLAG_EN 2
`define STS_TX_EMPTY 3
`define STS_OVERFLOW 4
`define STS_MODE_FAULT 5
`define STS_ERR_IRQ_EN 6
`define STS_RX_FULL 7
`define DATA_BITS 8
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define BIT_ONE 3'h1
`define DIV_CNT_W 7
`define CAP_LAG 5
`endif

// ---- tb/serial_port_props.sv ----
// Purpose: concurrent checks on serial port pins and bus
// Assumes: sees only top-level ports
// Notes: bound to every serial_port instance
`timescale 1ns/1ps
module serial_port_props (
  input wire sys_clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire sck_oe_o,
  input wire mosi_oe_o,
  input wire miso_oe_o,
  input wire select_n_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  chk_ready_high: assert property (pready_o)
    else $error("ready low");
  chk_err_access: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access");
  chk_rdata_quiet: assert property (!(psel_i && penable_i) |-> prdata_o == 32'h0)
    else $error("read data outside access");
  chk_master_no_miso: assert property (sck_oe_o |-> !miso_oe_o)
    else $error("master drives miso");
  chk_master_pins: assert property (mosi_oe_o == sck_oe_o)
    else $error("master pins disagree");
  chk_miso_release: assert property ($rose(select_n_i) |-> ##[1:6] !miso_oe_o)
    else $error("miso held after deselect");
  chk_miso_select: assert property ($rose(miso_oe_o) |-> !select_n_i && !$past(select_n_i))
    else $error("miso driven unselected");
  chk_reset_quiet: assert property ($fell(reset_i) |-> !sck_oe_o && !miso_oe_o)
    else $error("pins driven after reset");
endmodule // serial_port_props
bind serial_port serial_port_props serial_port_props_i (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .sck_oe_o(sck_oe_o), .mosi_oe_o(mosi_oe_o),
  .miso_oe_o(miso_oe_o), .select_n_i(select_n_i));

// ---- tb/spi_peer.sv ----
// Purpose: behavioural external slave on the serial pins
// Assumes: polarity and phase match the port
// Notes: a released data line shows the inverse of its last value
`timescale 1ns/1ps
module spi_peer (
  input wire sck_i,
  input wire mosi_i,
  input wire cs_n_i,
  input wire cpol_i,
  input wire cpha_i,
  input wire [7:0] tx_i,
  output reg miso_o,
  output reg [7:0] rx_o
);
  reg [7:0] sh;
  initial miso_o = 1'b1;
  always @(negedge cs_n_i) begin
    sh = tx_i;
    if (!cpha_i) miso_o = sh[7];
  end
  always @(posedge cs_n_i) miso_o = ~miso_o;
  always @(sck_i) begin
    if (!cs_n_i && ((sck_i !== cpol_i) ^ cpha_i)) begin
      rx_o = {rx_o[6:0], mosi_i};
    end else if (!cs_n_i) begin
      if (!cpha_i) sh = {sh[6:0], 1'b0};
      miso_o = sh[7];
      if (cpha_i) sh = {sh[6:0], 1'b0};
    end
  end
endmodule // spi_peer

// ---- tb/tb_serial_port.sv ----
// Purpose: self-checking bench for serial_port
// Assumes: 10 MHz clock, peer slave on the serial pins
// Notes: a monitor checks each read against the oldest queued note
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module tb_serial_port;
  reg clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sck_m = 0, mosi_m = 0, sel_n = 1;
  reg pcs_n = 1, cpol = 0, cpha = 0;
  reg [11:0] pa = 0;
  reg [31:0] pwd = 0;
  reg [7:0] ptx = 0, b, d, q;
  reg [63:0] e;
  wire [31:0] prd;
  wire [7:0] prx;
  wire rdy, err, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, miso_p, irq;
  wire sck_w = sck_oe ? sck_o : sck_m;
  wire mosi_w = mosi_oe ? mosi_o : mosi_m;
  wire miso_w = miso_oe ? miso_o : miso_p;
  integer fail_count = 0, n_checks = 0, cyc = 0, i;
  reg [63:0] exp_q[$];
  initial forever #50 clk = ~clk;
  serial_port serial_port_i (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe), .mosi_i(mosi_w),
    .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_o(miso_oe), .select_n_i(sel_n), .irq_o(irq));
  spi_peer spi_peer_i (.sck_i(sck_w), .mosi_i(mosi_w), .cs_n_i(pcs_n), .cpol_i(cpol),
    .cpha_i(cpha), .tx_i(ptx), .miso_o(miso_p), .rx_o(prx));
  task check(input [31:0] seen, input [31:0] want);
    n_checks = n_checks + 1;
    if (seen !== want) begin
      fail_count = fail_count + 1;
      $display("FAIL %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task summarize;
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // for reads, dv is the expected value under mask m
  task apb(input w, input [11:0] a, input [31:0] dv, input [31:0] m);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= dv;
    if (!w) exp_q.push_back({m, dv});
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    psel <= 0; pen <= 0;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin fail_count = fail_count + 1; summarize; end
    if (psel && pen && !pwr && rdy === 1'b1) begin
      e = exp_q.pop_front();
      check(prd & e[63:32], e[31:0]);
    end
  end
  task mxfer(input [7:0] dv, input integer hb);
    repeat (2) @(posedge clk);
    pcs_n = 0;
    apb(1, `OFS_DATA, dv, 0);
    repeat (16) @(sck_w);
    repeat (4 * hb + 8) @(posedge clk);
    pcs_n = 1;
  endtask
  // external master, cpha 1, ten cycles per clock phase
  task sxfer(input [7:0] dv, output [7:0] qv);
    integer k;
    sel_n <= 0;
    repeat (10) @(posedge clk);
    for (k = 7; k >= 0; k = k - 1) begin
      sck_m <= 1; mosi_m <= dv[k];
      repeat (10) @(posedge clk);
      sck_m <= 0; qv = {qv[6:0], miso_w};
      repeat (10) @(posedge clk);
    end
    sel_n <= 1; mosi_m <= ~mosi_m;
  endtask
  initial begin
    i = $urandom(29);
    repeat (3) @(posedge clk);
    rst <= 0;
    apb(0, `OFS_CONTROL, 32'h02, 32'h7f);
    apb(0, `OFS_STATUS, 32'h08, 32'hb8);
    apb(0, 12'h00c, 0, 32'hffffffff);
    for (i = 0; i < 4; i = i + 1) begin
      cpol = i[0]; cpha = i[1];
      apb(1, `OFS_CONTROL, 0, 0);
      apb(1, `OFS_STATUS, i, 0);
      apb(1, `OFS_CONTROL, 32'h62 | (i * 4), 0);
      ptx = $urandom; b = $urandom;
      mxfer(b, 1 << (2 * i));
      check(prx, b);
      check(irq, 1'b0);
      apb(0, `OFS_CONTROL, 0, 32'h40);
      apb(0, `OFS_STATUS, 32'h88, 32'hb8);
      apb(0, `OFS_DATA, ptx, 32'hff);
      apb(0, `OFS_STATUS, 32'h08, 32'hb8);
    end
    b = $urandom; ptx = b;
    mxfer($urandom, 64);
    ptx = ~b;
    mxfer($urandom, 64);
    apb(0, `OFS_STATUS, 32'h98, 32'hb8);
    apb(0, `OFS_DATA, b, 32'hff);
    apb(0, `OFS_STATUS, 32'h08, 32'hb8);
    apb(1, `OFS_STATUS, 32'h04, 0);
    sel_n <= 0;
    repeat (10) @(posedge clk);
    apb(0, `OFS_STATUS, 32'h28, 32'h28);
    apb(0, `OFS_CONTROL, 32'h02, 32'h22);
    sel_n <= 1;
    repeat (10) @(posedge clk);
    apb(0, `OFS_STATUS, 0, 0);
    apb(1, `OFS_CONTROL, 32'h28, 0);
    b = $urandom; d = $urandom;
    apb(1, `OFS_DATA, b, 0);
    sxfer(d, q);
    check(q, b);
    repeat (10) @(posedge clk);
    apb(0, `OFS_STATUS, 32'h80, 32'hb0);
    apb(0, `OFS_DATA, d, 32'hff);
    sxfer(~d, q);
    check(q, d);
    apb(1, `OFS_CONTROL, 0, 0);
    apb(1, `OFS_CONTROL, 32'h20, 0);
    sel_n <= 0;
    repeat (10) @(posedge clk);
    sel_n <= 1;
    repeat (10) @(posedge clk);
    apb(0, `OFS_STATUS, 32'h20, 32'h20);
    summarize;
  end
endmodule // tb_serial_port
